// >>> hw/bsw_stopwatch.sv
// two-digit bcd stopwatch timer with axi4-lite register slave
//
// Functional notes
// RULE1: two cascaded 4-bit bcd digits, readable, lower one near 100 Hz.
// RULE2: lower digit steps from 256 Hz at spacings of two and three ticks.
// RULE3: upper digit steps on lower wraps, ten of them make one second.
// RULE4: lower 9-to-0 wrap sets tenth flag, upper wrap sets one-sec flag.
// RULE5: flags set on wraps whatever the mask; mask gates only the request.
// RULE6: mask bit 0 is tenth-second, bit 1 one-second, one enables.
// RULE7: flags read one after an event, write one clears, zero does nothing.
// RULE8: both digits are read-only, writes ignored, reset clears them.
// RULE9: writing one to control bit 1 clears both digits, it reads as zero.
// RULE10: clear while running resumes from zero, while stopped holds zero.
// RULE11: control bit 0 is readable run enable; digits hold while it is zero.
// RULE12: reset clears run enable so the stopwatch starts stopped.
// RULE13: software stops, reads both digits, restarts within 976 us.
// RULE14: reset clears both mask bits and both event flags.
// RULE15: the handler clears the pending flag before re-enabling interrupts.
// RULE16: interrupt request is high while a flag and its enable are set.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module bsw_stopwatch
#(
   parameter int ADDR_W = bsw_pkg::ADDR_W,
   parameter int DATA_W = bsw_pkg::DATA_W
)
(
   input  wire logic                sys_clk_in,
   input  wire logic                srst_in,
   input  wire logic                ce_in,
   input  wire logic                tick_256hz_in,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
   input  wire logic                s_axi_awvalid_in,
   output logic                     s_axi_awready_out,
   input  wire logic [DATA_W-1:0]   s_axi_wdata_in,
   input  wire logic [DATA_W/8-1:0] s_axi_wstrb_in,
   input  wire logic                s_axi_wvalid_in,
   output logic                     s_axi_wready_out,
   output logic [1:0]               s_axi_bresp_out,
   output logic                     s_axi_bvalid_out,
   input  wire logic                s_axi_bready_in,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
   input  wire logic                s_axi_arvalid_in,
   output logic                     s_axi_arready_out,
   output logic [DATA_W-1:0]        s_axi_rdata_out,
   output logic [1:0]               s_axi_rresp_out,
   output logic                     s_axi_rvalid_out,
   input  wire logic                s_axi_rready_in,
   output logic                     irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // address decode, shared by the write and read paths

   function automatic bsw_pkg::bsw_sel_t decode_sel
   (
      input logic [ADDR_W-1:0] addr
   );
      logic [bsw_pkg::IDX_W-1:0] idx;
      idx = addr[bsw_pkg::BYTE_SHIFT +: bsw_pkg::IDX_W];
      case (idx)
         bsw_pkg::IDX_CTRL:  decode_sel = bsw_pkg::BSW_SEL_CTRL;
         bsw_pkg::IDX_HUND:  decode_sel = bsw_pkg::BSW_SEL_HUND;
         bsw_pkg::IDX_TENTH: decode_sel = bsw_pkg::BSW_SEL_TENTH;
         bsw_pkg::IDX_IEN:   decode_sel = bsw_pkg::BSW_SEL_IEN;
         bsw_pkg::IDX_FLAG:  decode_sel = bsw_pkg::BSW_SEL_FLAG;
         default:            decode_sel = bsw_pkg::BSW_SEL_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   localparam int DW = bsw_pkg::DIGIT_W;
   localparam int NE = bsw_pkg::NUM_EV;
   localparam int AW = bsw_pkg::ACC_W;

   logic [1:0]              tick_sync_r;
   logic                    tick_prev_r;
   logic                    tick;

   logic                    run_r;
   logic [DW-1:0]           hund_r;
   logic [DW-1:0]           tenth_r;
   logic [AW-1:0]           acc_r;
   logic [AW-1:0]           acc_sum;
   logic                    step;
   logic                    lo_wrap;
   logic                    hi_wrap;

   logic [NE-1:0]           mask_r;
   logic [NE-1:0]           flag_r;
   logic [NE-1:0]           event_set;
   logic [NE-1:0]           flag_clr;

   bsw_pkg::bsw_state_t     wstate_r;
   bsw_pkg::bsw_state_t     rstate_r;
   logic                    aw_hold_r;
   logic                    w_hold_r;
   logic [ADDR_W-1:0]       aw_addr_r;
   logic [DATA_W-1:0]       w_data_r;
   logic                    w_lane0_r;
   logic [1:0]              bresp_r;
   logic [DATA_W-1:0]       rdata_r;
   logic [1:0]              rresp_r;

   logic                    aw_take;
   logic                    w_take;
   logic                    wr_go;
   logic                    ar_take;
   bsw_pkg::bsw_sel_t       wr_sel;
   bsw_pkg::bsw_sel_t       rd_sel;
   logic                    wr_ctrl;
   logic                    wr_ien;
   logic                    wr_flag;
   logic                    clear_wr;
   logic [DATA_W-1:0]       rd_word;

   ////////////////////////////////////////////////////////////////////////
   // 256 Hz source from the low-speed oscillator domain

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         tick_sync_r <= 2'h0;
         tick_prev_r <= 1'b0;
      end
      else if (ce_in)
      begin
         tick_sync_r <= {tick_sync_r[0], tick_256hz_in};
         tick_prev_r <= tick_sync_r[1];
      end
   end

   // one pulse per rising edge of the synchronised source
   assign tick = tick_sync_r[1] & ~tick_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // step pattern and digit cascade

   // RULE2: 2/256 and 3/256 spacing
   // accumulating 100 per tick gives 100 evenly spread steps per 256
   assign acc_sum = acc_r + bsw_pkg::ACC_STEP;
   assign step    = run_r & tick & (acc_sum >= bsw_pkg::ACC_MOD);

   // RULE4: nine to zero wraps
   assign lo_wrap = step & (hund_r == bsw_pkg::DIGIT_MAX);
   // RULE3: upper clocked by lower wraps
   assign hi_wrap = lo_wrap & (tenth_r == bsw_pkg::DIGIT_MAX);

   // RULE9: clear bit write decode
   assign clear_wr = wr_ctrl & w_data_r[bsw_pkg::CLEAR_BIT];

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         acc_r <= bsw_pkg::ACC_ZERO;
      end
      else if (ce_in)
      begin
         // RULE10: clear restarts the phase too
         if (clear_wr)
         begin
            acc_r <= bsw_pkg::ACC_ZERO;
         end
         // RULE11: phase frozen while stopped
         else if (run_r && tick)
         begin
            if (acc_sum >= bsw_pkg::ACC_MOD)
            begin
               acc_r <= acc_sum - bsw_pkg::ACC_MOD;
            end
            else
            begin
               acc_r <= acc_sum;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      // RULE8: digits zero after reset
      if (srst_in)
      begin
         hund_r  <= bsw_pkg::DIGIT_ZERO;
         tenth_r <= bsw_pkg::DIGIT_ZERO;
      end
      else if (ce_in)
      begin
         // RULE9: clear zeroes both digits
         // clear wins over a step in the same cycle
         if (clear_wr)
         begin
            hund_r  <= bsw_pkg::DIGIT_ZERO;
            tenth_r <= bsw_pkg::DIGIT_ZERO;
         end
         // RULE1: cascaded bcd digits
         else if (step)
         begin
            if (lo_wrap)
            begin
               hund_r <= bsw_pkg::DIGIT_ZERO;
            end
            else
            begin
               hund_r <= hund_r + 4'h1;
            end
            if (hi_wrap)
            begin
               tenth_r <= bsw_pkg::DIGIT_ZERO;
            end
            else if (lo_wrap)
            begin
               tenth_r <= tenth_r + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control, mask and flag registers

   always_ff @(posedge sys_clk_in)
   begin
      // RULE12: stopped after reset
      if (srst_in)
      begin
         run_r <= 1'b0;
      end
      // RULE11: run enable write
      else if (ce_in && wr_ctrl)
      begin
         run_r <= w_data_r[bsw_pkg::RUN_BIT];
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      // RULE14: masks cleared at reset
      if (srst_in)
      begin
         mask_r <= bsw_pkg::EV_RESET;
      end
      // RULE6: mask write
      else if (ce_in && wr_ien)
      begin
         mask_r <= w_data_r[NE-1:0];
      end
   end

   // RULE5: events ignore the mask
   assign event_set[bsw_pkg::TENTH_BIT] = lo_wrap;
   assign event_set[bsw_pkg::ONE_BIT]   = hi_wrap;
   assign flag_clr = wr_flag ? w_data_r[NE-1:0] : bsw_pkg::EV_RESET;

   generate
      for (genvar i = 0; i < NE; i++)
      begin : g_flag
         always_ff @(posedge sys_clk_in)
         begin
            // RULE14: flags cleared at reset
            if (srst_in)
            begin
               flag_r[i] <= 1'b0;
            end
            // RULE7: write one clears, set wins
            else if (ce_in)
            begin
               flag_r[i] <= event_set[i] | (flag_r[i] & ~flag_clr[i]);
            end
         end
      end
   endgenerate

   // RULE16: level request from enabled flags
   assign irq_out = |(flag_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel

   // address and data may arrive in either order; each is parked
   assign s_axi_awready_out = ce_in & ~aw_hold_r;
   assign s_axi_wready_out  = ce_in & ~w_hold_r;
   assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
   assign w_take  = s_axi_wvalid_in & s_axi_wready_out;
   assign wr_go   = ce_in & aw_hold_r & w_hold_r
                    & (wstate_r == bsw_pkg::BSW_ST_IDLE);

   assign wr_sel  = decode_sel(aw_addr_r);
   // only lane 0 carries register bits, so it alone gates a write
   assign wr_ctrl = wr_go & w_lane0_r & (wr_sel == bsw_pkg::BSW_SEL_CTRL);
   assign wr_ien  = wr_go & w_lane0_r & (wr_sel == bsw_pkg::BSW_SEL_IEN);
   assign wr_flag = wr_go & w_lane0_r & (wr_sel == bsw_pkg::BSW_SEL_FLAG);

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
      end
      else if (ce_in)
      begin
         if (aw_take)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_in;
         end
         else if (wr_go)
         begin
            aw_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         w_hold_r  <= 1'b0;
         w_data_r  <= '0;
         w_lane0_r <= 1'b0;
      end
      else if (ce_in)
      begin
         if (w_take)
         begin
            w_hold_r  <= 1'b1;
            w_data_r  <= s_axi_wdata_in;
            w_lane0_r <= s_axi_wstrb_in[0];
         end
         else if (wr_go)
         begin
            w_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         wstate_r <= bsw_pkg::BSW_ST_IDLE;
         bresp_r  <= bsw_pkg::RESP_OKAY;
      end
      else if (ce_in)
      begin
         case (wstate_r)
            bsw_pkg::BSW_ST_IDLE:
            begin
               if (wr_go)
               begin
                  wstate_r <= bsw_pkg::BSW_ST_RESP;
                  // RULE8: digit writes accepted, ignored
                  if (wr_sel == bsw_pkg::BSW_SEL_NONE)
                  begin
                     bresp_r <= bsw_pkg::RESP_SLVERR;
                  end
                  else
                  begin
                     bresp_r <= bsw_pkg::RESP_OKAY;
                  end
               end
            end
            bsw_pkg::BSW_ST_RESP:
            begin
               if (s_axi_bready_in)
               begin
                  wstate_r <= bsw_pkg::BSW_ST_IDLE;
               end
            end
            default:
            begin
               wstate_r <= bsw_pkg::BSW_ST_IDLE;
            end
         endcase
      end
   end

   assign s_axi_bvalid_out = (wstate_r == bsw_pkg::BSW_ST_RESP);
   assign s_axi_bresp_out  = bresp_r;

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   assign s_axi_arready_out = ce_in & (rstate_r == bsw_pkg::BSW_ST_IDLE);
   assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
   assign rd_sel  = decode_sel(s_axi_araddr_in);

   always_comb
   begin
      rd_word = '0;
      case (rd_sel)
         // RULE9: clear bit reads as zero
         bsw_pkg::BSW_SEL_CTRL: rd_word[bsw_pkg::RUN_BIT] = run_r;
         bsw_pkg::BSW_SEL_HUND: rd_word[DW-1:0] = hund_r;
         bsw_pkg::BSW_SEL_TENTH: rd_word[DW-1:0] = tenth_r;
         bsw_pkg::BSW_SEL_IEN: rd_word[NE-1:0] = mask_r;
         bsw_pkg::BSW_SEL_FLAG: rd_word[NE-1:0] = flag_r;
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         rstate_r <= bsw_pkg::BSW_ST_IDLE;
         rdata_r  <= '0;
         rresp_r  <= bsw_pkg::RESP_OKAY;
      end
      else if (ce_in)
      begin
         case (rstate_r)
            bsw_pkg::BSW_ST_IDLE:
            begin
               if (ar_take)
               begin
                  rstate_r <= bsw_pkg::BSW_ST_RESP;
                  rdata_r  <= rd_word;
                  if (rd_sel == bsw_pkg::BSW_SEL_NONE)
                  begin
                     rresp_r <= bsw_pkg::RESP_SLVERR;
                  end
                  else
                  begin
                     rresp_r <= bsw_pkg::RESP_OKAY;
                  end
               end
            end
            bsw_pkg::BSW_ST_RESP:
            begin
               if (s_axi_rready_in)
               begin
                  rstate_r <= bsw_pkg::BSW_ST_IDLE;
               end
            end
            default:
            begin
               rstate_r <= bsw_pkg::BSW_ST_IDLE;
            end
         endcase
      end
   end

   assign s_axi_rvalid_out = (rstate_r == bsw_pkg::BSW_ST_RESP);
   assign s_axi_rdata_out  = rdata_r;
   assign s_axi_rresp_out  = rresp_r;

endmodule

// >>> pkg/bsw_pkg.sv
// constants and types shared by the stopwatch timer block
package bsw_pkg;

   // bus geometry
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 32;
   localparam int IDX_W      = 16;
   localparam int BYTE_SHIFT = 2;

   // register indices; byte address is index times four
   localparam logic [IDX_W-1:0] IDX_CTRL  = 16'hFF7C;
   localparam logic [IDX_W-1:0] IDX_HUND  = 16'hFF7D;
   localparam logic [IDX_W-1:0] IDX_TENTH = 16'hFF7E;
   localparam logic [IDX_W-1:0] IDX_IEN   = 16'hFFE7;
   localparam logic [IDX_W-1:0] IDX_FLAG  = 16'hFFF7;

   // field positions
   localparam int RUN_BIT   = 0;
   localparam int CLEAR_BIT = 1;
   localparam int TENTH_BIT = 0;
   localparam int ONE_BIT   = 1;
   localparam int NUM_EV    = 2;
   localparam int DIGIT_W   = 4;

   // reset and digit values
   localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
   localparam logic [DIGIT_W-1:0] DIGIT_MAX  = 4'h9;
   localparam logic [NUM_EV-1:0]  EV_RESET   = 2'h0;

   // step pattern: 100 steps spread over 256 source ticks
   localparam int TICK_HZ = 256;
   localparam int STEP_HZ = 100;
   localparam int ACC_W   = 9;
   localparam logic [ACC_W-1:0] ACC_ZERO = 9'h000;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(STEP_HZ);
   localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(TICK_HZ);

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      BSW_SEL_NONE  = 3'h0,
      BSW_SEL_CTRL  = 3'h1,
      BSW_SEL_HUND  = 3'h2,
      BSW_SEL_TENTH = 3'h3,
      BSW_SEL_IEN   = 3'h4,
      BSW_SEL_FLAG  = 3'h5
   } bsw_sel_t;

   typedef enum logic [1:0] {
      BSW_ST_IDLE = 2'b01,
      BSW_ST_RESP = 2'b10
   } bsw_state_t;

endpackage

// >>> test/bcd_stopwatch_timer_test.sv
// self-checking bench for the stopwatch register slave
`timescale 1ns/1ps

module bcd_stopwatch_timer_test;

   localparam logic [17:0] A_CTRL  = {bsw_pkg::IDX_CTRL, 2'b00};
   localparam logic [17:0] A_HUND  = {bsw_pkg::IDX_HUND, 2'b00};
   localparam logic [17:0] A_TENTH = {bsw_pkg::IDX_TENTH, 2'b00};
   localparam logic [17:0] A_IEN   = {bsw_pkg::IDX_IEN, 2'b00};
   localparam logic [17:0] A_FLAG  = {bsw_pkg::IDX_FLAG, 2'b00};
   localparam logic [17:0] A_BAD   = 18'h00010;

   logic        sys_clk_in;
   logic        srst_in;
   logic        tick_in;
   logic        ce;
   logic [3:0]  wstrb;
   logic [17:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [17:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        irq_out;
   logic [31:0] rdv;
   logic [1:0]  rsp;
   int          n_mismatch;
   int          comparisons;

   ////////////////////////////////////////////////////////////////////////
   bsw_stopwatch bsw_stopwatch_inst (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce),
      .tick_256hz_in(tick_in), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .irq_out(irq_out));

   always #5 sys_clk_in = ~sys_clk_in;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // entered just after a rising edge; readiness sampled mid-cycle
   task automatic axi_write(input logic [17:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      logic aw_hit;
      logic w_hit;
      logic done;
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(negedge sys_clk_in);
         aw_hit = awvalid & awready;
         w_hit  = wvalid & wready;
         done   = bvalid & bready;
         r      = bresp;
         @(posedge sys_clk_in);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         // bready left high, a back-to-back call would assign it twice
      end
   endtask

   task automatic axi_read(input logic [17:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic ar_hit;
      logic done;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(negedge sys_clk_in);
         ar_hit = arvalid & arready;
         done   = rvalid & rready;
         d      = rdata;
         r      = rresp;
         @(posedge sys_clk_in);
         if (ar_hit) arvalid <= 1'b0;
         // rready left high for the same reason
      end
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      axi_write(a, d, rsp);
   endtask

   task automatic rd(input string nm, input logic [17:0] a,
                     input logic [31:0] e);
      axi_read(a, rdv, rsp);
      check(nm, rdv, e);
   endtask

   task automatic chk_irq(input logic e);
      @(negedge sys_clk_in);
      check("irq", {31'h0, irq_out}, {31'h0, e});
      @(posedge sys_clk_in);
   endtask

   // source ticks much faster than 256 Hz to keep the run short
   task automatic tick(input int n);
      repeat (n)
      begin
         tick_in <= 1'b1;
         repeat (4) @(posedge sys_clk_in);
         tick_in <= 1'b0;
         repeat (4) @(posedge sys_clk_in);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #300000;
      n_mismatch++;
      summarize();
   end

   initial
   begin
      sys_clk_in = 1'b0;
      srst_in = 1'b1;
      tick_in = 1'b0;
      ce = 1'b1;
      wstrb = 4'hF;
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (6) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      rd("ctrl", A_CTRL, 32'h0);
      rd("hund", A_HUND, 32'h0);
      rd("tenth", A_TENTH, 32'h0);
      rd("mask", A_IEN, 32'h0);
      rd("flags", A_FLAG, 32'h0);
      axi_read(A_BAD, rdv, rsp);
      check("bad rresp", {30'h0, rsp}, {30'h0, bsw_pkg::RESP_SLVERR});
      axi_write(A_BAD, 32'h1, rsp);
      check("bad bresp", {30'h0, rsp}, {30'h0, bsw_pkg::RESP_SLVERR});
      wr(A_HUND, 32'h5);
      rd("hund write", A_HUND, 32'h0);
      tick(6);
      rd("hund stopped", A_HUND, 32'h0);
      wr(A_IEN, 32'h3);
      rd("mask rw", A_IEN, 32'h3);
      chk_irq(1'b0);
      wr(A_IEN, 32'h0);
      // lane 0 disabled, so the write must not land
      wstrb <= 4'hE;
      wr(A_IEN, 32'h3);
      wstrb <= 4'hF;
      rd("mask strb", A_IEN, 32'h0);
      wr(A_CTRL, 32'h1);
      rd("ctrl run", A_CTRL, 32'h1);
      tick(2);
      rd("hund 2", A_HUND, 32'h0);
      tick(1);
      rd("hund 3", A_HUND, 32'h1);
      tick(22);
      rd("hund 25", A_HUND, 32'h9);
      rd("flags 25", A_FLAG, 32'h0);
      tick(1);
      rd("hund 26", A_HUND, 32'h0);
      rd("tenth 26", A_TENTH, 32'h1);
      rd("flags 26", A_FLAG, 32'h1);
      chk_irq(1'b0);
      wr(A_IEN, 32'h1);
      chk_irq(1'b1);
      wr(A_FLAG, 32'h0);
      rd("flags w0", A_FLAG, 32'h1);
      wr(A_FLAG, 32'h1);
      rd("flags w1", A_FLAG, 32'h0);
      chk_irq(1'b0);
      wr(A_CTRL, 32'h0);
      tick(5);
      rd("hund held", A_HUND, 32'h0);
      rd("tenth held", A_TENTH, 32'h1);
      wr(A_CTRL, 32'h1);
      tick(3);
      rd("hund resume", A_HUND, 32'h1);
      wr(A_CTRL, 32'h0);
      rd("hund snap", A_HUND, 32'h1);
      rd("tenth snap", A_TENTH, 32'h1);
      wr(A_CTRL, 32'h1);
      // source ticks while the enable is low must be lost
      ce <= 1'b0;
      tick(3);
      ce <= 1'b1;
      rd("hund frozen", A_HUND, 32'h1);
      wr(A_CTRL, 32'h3);
      rd("hund clr", A_HUND, 32'h0);
      rd("tenth clr", A_TENTH, 32'h0);
      rd("ctrl clr", A_CTRL, 32'h1);
      tick(3);
      rd("hund run clr", A_HUND, 32'h1);
      wr(A_CTRL, 32'h0);
      wr(A_CTRL, 32'h2);
      rd("hund stop clr", A_HUND, 32'h0);
      rd("ctrl stop clr", A_CTRL, 32'h0);
      tick(3);
      rd("hund kept 0", A_HUND, 32'h0);
      wr(A_IEN, 32'h2);
      wr(A_CTRL, 32'h1);
      tick(255);
      rd("hund 255", A_HUND, 32'h9);
      rd("tenth 255", A_TENTH, 32'h9);
      tick(1);
      rd("hund 256", A_HUND, 32'h0);
      rd("tenth 256", A_TENTH, 32'h0);
      rd("flags 256", A_FLAG, 32'h3);
      chk_irq(1'b1);
      wr(A_FLAG, 32'h2);
      rd("flags one", A_FLAG, 32'h1);
      chk_irq(1'b0);
      summarize();
   end

endmodule

// >>> test/bsw_checker.sv
// assertion checker for the stopwatch register slave
`timescale 1ns/1ps

module bsw_checker
#(
   parameter int ADDR_W = bsw_pkg::ADDR_W,
   parameter int DATA_W = bsw_pkg::DATA_W
)
(
   input wire logic              sys_clk_in,
   input wire logic              srst_in,
   input wire logic              s_axi_awvalid_in,
   input wire logic              s_axi_awready_out,
   input wire logic              s_axi_wvalid_in,
   input wire logic              s_axi_wready_out,
   input wire logic [1:0]        s_axi_bresp_out,
   input wire logic              s_axi_bvalid_out,
   input wire logic              s_axi_bready_in,
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic              s_axi_arvalid_in,
   input wire logic              s_axi_arready_out,
   input wire logic [DATA_W-1:0] s_axi_rdata_out,
   input wire logic [1:0]        s_axi_rresp_out,
   input wire logic              s_axi_rvalid_out,
   input wire logic              s_axi_rready_in,
   input wire logic              irq_out
);

   ////////////////////////////////////////////////////////////////////////
   logic [bsw_pkg::IDX_W-1:0] ar_idx;
   logic                      ar_take;
   logic                      ar_map;
   logic                      ar_dig;

   assign ar_idx  = s_axi_araddr_in[ADDR_W-1:2];
   assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
   assign ar_dig  = (ar_idx == bsw_pkg::IDX_HUND) |
                    (ar_idx == bsw_pkg::IDX_TENTH);
   assign ar_map  = ar_dig | (ar_idx == bsw_pkg::IDX_CTRL) |
                    (ar_idx == bsw_pkg::IDX_IEN) |
                    (ar_idx == bsw_pkg::IDX_FLAG);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   a_reset_quiet: assert property ($fell(srst_in) |->
      !irq_out && !s_axi_bvalid_out && !s_axi_rvalid_out)
      else $error("outputs not idle after reset");
   a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped early");
   a_ar_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted during response");
   a_read_answer: assert property (ar_take |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out)
      else $error("write answer late");
   a_clear_reads0: assert property (ar_take &&
      ar_idx == bsw_pkg::IDX_CTRL |=> s_axi_rdata_out[DATA_W-1:1] == '0)
      else $error("control upper bits not zero");
   a_digit_bcd: assert property (ar_take && ar_dig |=>
      s_axi_rdata_out <= DATA_W'(bsw_pkg::DIGIT_MAX))
      else $error("digit out of bcd range");
   a_unmapped_err: assert property (ar_take && !ar_map |=>
      s_axi_rresp_out == bsw_pkg::RESP_SLVERR && s_axi_rdata_out == '0)
      else $error("unmapped read not refused");
   c_irq_seen: cover property ($rose(irq_out));

endmodule

bind bsw_stopwatch bsw_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   bsw_checker_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .irq_out(irq_out));
